/* File: inc/cpu_state_pkg.sv */
// Constants and types shared by the processor state register bank
`default_nettype none
package cpu_state_pkg;

	// Register widths
	localparam int XLEN = 64;
	localparam int VID_W = 32;

	// Special-register selector used by the move instructions
	typedef enum logic [1:0] {
		SPR_STATE = 2'b00,
		SPR_VERSION = 2'b01,
		SPR_PTDESC = 2'b10,
		SPR_SEGPTR = 2'b11
	} spr_sel_t;

	// Floating-point trap mode, first bit then second bit
	typedef enum logic [1:0] {
		FP_TRAP_OFF = 2'b00,
		FP_IMPRECISE_NONREC = 2'b01,
		FP_IMPRECISE_REC = 2'b10,
		FP_PRECISE = 2'b11
	} fp_trap_mode_t;

	// Optional facilities present in this implementation
	localparam logic HAS_BYTE_ORDER = 1'b1;
	localparam logic HAS_PERF_MARK = 1'b1;

	// State word bit positions; bit 0 is the most significant bit
	localparam int MSW_WIDE_POS = 63 - 0;
	localparam int MSW_NAP_POS = 63 - 45;
	localparam int MSW_TRAP_ORDER_POS = 63 - 47;
	localparam int MSW_EXT_IRQ_POS = 63 - 48;
	localparam int MSW_USER_POS = 63 - 49;
	localparam int MSW_FLOAT_POS = 63 - 50;
	localparam int MSW_MCHECK_POS = 63 - 51;
	localparam int MSW_FP_A_POS = 63 - 52;
	localparam int MSW_STEP_POS = 63 - 53;
	localparam int MSW_BRANCH_POS = 63 - 54;
	localparam int MSW_FP_B_POS = 63 - 55;
	localparam int MSW_INSN_XLATE_POS = 63 - 58;
	localparam int MSW_DATA_XLATE_POS = 63 - 59;
	localparam int MSW_PERF_POS = 63 - 61;
	localparam int MSW_RESUME_POS = 63 - 62;
	localparam int MSW_ORDER_POS = 63 - 63;

	// Power-up value: only wide mode set, undefined bits forced to 0
	localparam logic [63:0] MSW_RESET = 64'h8000_0000_0000_0000;

	// Bits that exist and can be written; the rest read as zero
	localparam logic [63:0] MSW_WMASK =
		(64'h1 << MSW_WIDE_POS) | (64'h1 << MSW_NAP_POS) |
		(64'h1 << MSW_TRAP_ORDER_POS) | (64'h1 << MSW_EXT_IRQ_POS) |
		(64'h1 << MSW_USER_POS) | (64'h1 << MSW_FLOAT_POS) |
		(64'h1 << MSW_MCHECK_POS) | (64'h1 << MSW_FP_A_POS) |
		(64'h1 << MSW_STEP_POS) | (64'h1 << MSW_BRANCH_POS) |
		(64'h1 << MSW_FP_B_POS) | (64'h1 << MSW_INSN_XLATE_POS) |
		(64'h1 << MSW_DATA_XLATE_POS) | (64'h1 << MSW_RESUME_POS) |
		({63'h0, HAS_PERF_MARK} << MSW_PERF_POS) |
		({63'h0, HAS_BYTE_ORDER} << MSW_ORDER_POS);

	// Version register fields: version code high, revision low
	localparam int VID_CODE_LSB = 16;
	localparam int VID_REV_LSB = 0;
	// Arbitrary neutral identification values
	localparam logic [15:0] VERSION_CODE = 16'h5a01;
	localparam logic [15:0] REVISION_LEVEL = 16'h0001;

	// Page table descriptor fields
	localparam int PTD_BASE_LSB = 63 - 45;
	localparam int PTD_BASE_W = 44;
	localparam int PTD_SIZE_LSB = 63 - 63;
	localparam int PTD_SIZE_W = 5;
	localparam logic [63:0] PTD_RESET = 64'h0;
	localparam logic [63:0] PTD_WMASK = 64'h3fff_ffff_fffc_001f;
	localparam int PT_ALIGN_BITS = 18;
	localparam int MIN_HASH_BITS = 11;
	localparam int EXTRA_HASH_MAX = 28;
	localparam logic [4:0] SIZE_LIMIT = 5'h1c;
	localparam logic [4:0] SIZE_LIMIT_VA64 = 5'h19;

	// Segment table pointer: all bits reserved, reads zero
	localparam logic [63:0] SEGPTR_VALUE = 64'h0;

endpackage
`default_nettype wire

/* File: rtl/cpu_state_regs.sv */
// Processor state word, version, page table and segment registers
`default_nettype none
module cpu_state_regs
	import cpu_state_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire spr_sel_t spr_sel,
	input wire logic spr_rd_en,
	input wire logic spr_wr_en,
	input wire logic [63:0] spr_wdata,
	output logic [63:0] spr_rdata,
	output logic spr_rd_valid,
	output logic spr_priv_fault,
	output logic wide_mode,
	output logic nap_enable,
	output logic trap_byte_order,
	output logic ext_irq_on,
	output logic user_mode_bit,
	output logic float_unit_on,
	output logic mcheck_on,
	output logic single_step_trace,
	output logic branch_trace,
	output logic insn_xlate_on,
	output logic data_xlate_on,
	output logic perf_mark,
	output logic resumable_flag,
	output logic byte_order_bit,
	output fp_trap_mode_t fp_trap_mode,
	output logic fp_exc_enabled,
	output logic fp_precise,
	output logic fp_recoverable,
	output logic [63:0] table_base_addr,
	output logic [EXTRA_HASH_MAX-1:0] table_hash_mask,
	output logic [5:0] table_index_bits,
	output logic table_size_over_limit,
	output logic table_size_over_va64
);

	// Architected state
	logic [63:0] msw_reg;
	logic [63:0] msw_next;
	logic [63:0] ptd_reg;
	logic [63:0] ptd_next;
	logic [63:0] rdata_reg;
	logic [63:0] rdata_next;
	logic rd_valid_reg;
	logic fault_reg;
	logic fault_next;

	// Access decode
	logic wr_state;
	logic wr_ptdesc;
	logic rd_version;
	logic version_denied;
	logic [31:0] version_word;
	logic [63:0] read_mux;
	logic [4:0] size_field;

	// Only the existing bits take writes; reserved ones stay zero
	assign wr_state = spr_wr_en && (spr_sel == SPR_STATE);
	assign wr_ptdesc = spr_wr_en && (spr_sel == SPR_PTDESC);
	assign msw_next = wr_state ? (spr_wdata & MSW_WMASK) : msw_reg;
	assign ptd_next = wr_ptdesc ? (spr_wdata & PTD_WMASK) : ptd_reg;

	// Version and segment pointer selects have no write path at all
	assign version_word = {VERSION_CODE, REVISION_LEVEL};

	// Version reads need supervisor state, checked on current state
	assign rd_version = spr_rd_en && (spr_sel == SPR_VERSION);
	assign version_denied = rd_version && user_mode_bit;

	// Read selection; a denied read returns zero
	always_comb
	begin
		read_mux = 64'h0;
		unique case (spr_sel)
			SPR_STATE:
			begin
				read_mux = msw_reg;
			end
			SPR_VERSION:
			begin
				read_mux = {32'h0, version_word};
			end
			SPR_PTDESC:
			begin
				read_mux = ptd_reg;
			end
			SPR_SEGPTR:
			begin
				read_mux = SEGPTR_VALUE;
			end
		endcase
	end

	// Read data holds until the next read completes
	assign rdata_next = !spr_rd_en ? rdata_reg :
		(version_denied ? 64'h0 : read_mux);
	assign fault_next = version_denied;

	// State word; undefined power-up bits are simply forced to zero
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			msw_reg <= MSW_RESET;
		end
		else
		begin
			msw_reg <= msw_next;
		end
	end

	// Page table descriptor
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ptd_reg <= PTD_RESET;
		end
		else
		begin
			ptd_reg <= ptd_next;
		end
	end

	// Registered read answer, one cycle after the request
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata_reg <= 64'h0;
			rd_valid_reg <= 1'b0;
			fault_reg <= 1'b0;
		end
		else
		begin
			rdata_reg <= rdata_next;
			rd_valid_reg <= spr_rd_en;
			fault_reg <= fault_next;
		end
	end

	assign spr_rdata = rdata_reg;
	assign spr_rd_valid = rd_valid_reg;
	assign spr_priv_fault = fault_reg;

	// Mode outputs straight from the state word flops
	assign wide_mode = msw_reg[MSW_WIDE_POS];
	assign nap_enable = msw_reg[MSW_NAP_POS];
	assign trap_byte_order = msw_reg[MSW_TRAP_ORDER_POS];
	assign ext_irq_on = msw_reg[MSW_EXT_IRQ_POS];
	assign user_mode_bit = msw_reg[MSW_USER_POS];
	assign float_unit_on = msw_reg[MSW_FLOAT_POS];
	assign mcheck_on = msw_reg[MSW_MCHECK_POS];
	assign single_step_trace = msw_reg[MSW_STEP_POS];
	assign branch_trace = msw_reg[MSW_BRANCH_POS];
	assign insn_xlate_on = msw_reg[MSW_INSN_XLATE_POS];
	assign data_xlate_on = msw_reg[MSW_DATA_XLATE_POS];
	assign resumable_flag = msw_reg[MSW_RESUME_POS];

	// Optional bits read as zero when the facility is absent
	assign perf_mark = HAS_PERF_MARK & msw_reg[MSW_PERF_POS];
	assign byte_order_bit = HAS_BYTE_ORDER & msw_reg[MSW_ORDER_POS];

	// Float trap mode pair
	fp_trap_decode u_fp_decode (
		.mode_a(msw_reg[MSW_FP_A_POS]),
		.mode_b(msw_reg[MSW_FP_B_POS]),
		.mode(fp_trap_mode),
		.exc_enabled(fp_exc_enabled),
		.precise(fp_precise),
		.recoverable(fp_recoverable)
	);

	// Base field lands on address bits 61..18, so 2^18 alignment
	assign table_base_addr = {2'b00,
		ptd_reg[PTD_BASE_LSB +: PTD_BASE_W],
		{PT_ALIGN_BITS{1'b0}}};

	// Size field; values past the limit are flagged, not trusted
	assign size_field = ptd_reg[PTD_SIZE_LSB +: PTD_SIZE_W];

	pt_mask_expand u_mask (
		.size_field(size_field),
		.mask(table_hash_mask),
		.index_bits(table_index_bits),
		.over_limit(table_size_over_limit),
		.over_va64(table_size_over_va64)
	);

endmodule
`default_nettype wire

/* File: rtl/fp_trap_decode.sv */
// Decoder for the floating-point trap mode bit pair
`default_nettype none
module fp_trap_decode
	import cpu_state_pkg::*;
(
	input wire logic mode_a,
	input wire logic mode_b,
	output fp_trap_mode_t mode,
	output logic exc_enabled,
	output logic precise,
	output logic recoverable
);

	// First bit is the high bit of the code
	assign mode = fp_trap_mode_t'({mode_a, mode_b});
	assign exc_enabled = (mode != FP_TRAP_OFF);
	assign precise = (mode == FP_PRECISE);
	// Precise mode is recoverable as well as the imprecise one
	assign recoverable = (mode == FP_IMPRECISE_REC) || precise;

endmodule
`default_nettype wire

/* File: rtl/pt_mask_expand.sv */
// Expands the page table size field into a hash index mask
`default_nettype none
module pt_mask_expand
	import cpu_state_pkg::*;
(
	input wire logic [4:0] size_field,
	output logic [EXTRA_HASH_MAX-1:0] mask,
	output logic [5:0] index_bits,
	output logic over_limit,
	output logic over_va64
);

	// Oversized values saturate so the mask never exceeds its width
	logic [4:0] size_sat;
	assign over_limit = (size_field > SIZE_LIMIT);
	assign over_va64 = (size_field > SIZE_LIMIT_VA64);
	assign size_sat = over_limit ? SIZE_LIMIT : size_field;

	// One mask bit per extra hash bit: ones from the low end
	genvar i;
	generate
		for (i = 0; i < EXTRA_HASH_MAX; i++)
		begin : g_mask
			assign mask[i] = (5'(i) < size_sat);
		end
	endgenerate

	// Total hash bits used: fixed minimum plus the extra ones
	assign index_bits = 6'(MIN_HASH_BITS) + {1'b0, size_sat};

endmodule
`default_nettype wire

/* File: sim/cpu_state_regs_checker.sv */
// Concurrent checks on the processor state register bank ports
`default_nettype none
module cpu_state_regs_checker
	import cpu_state_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire spr_sel_t spr_sel,
	input wire logic spr_rd_en,
	input wire logic spr_wr_en,
	input wire logic [63:0] spr_wdata,
	input wire logic [63:0] spr_rdata,
	input wire logic spr_rd_valid,
	input wire logic spr_priv_fault,
	input wire logic wide_mode,
	input wire logic user_mode_bit,
	input wire logic insn_xlate_on,
	input wire logic data_xlate_on,
	input wire logic resumable_flag,
	input wire logic byte_order_bit,
	input wire fp_trap_mode_t fp_trap_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Request shapes; privilege is judged by the mode bit at the request
	sequence st_wr;
		spr_wr_en && spr_sel == SPR_STATE;
	endsequence
	sequence vid_rd;
		spr_rd_en && spr_sel == SPR_VERSION;
	endsequence

	chk_read_latency: assert property (spr_rd_en |=> spr_rd_valid)
		else $error("read answer late");
	chk_no_stray_valid: assert property (!spr_rd_en |=> !spr_rd_valid)
		else $error("read valid without request");
	chk_insn_xlate: assert property (
		st_wr |=> insn_xlate_on == $past(spr_wdata[5]))
		else $error("instruction translation bit wrong");
	chk_data_xlate: assert property (
		st_wr |=> data_xlate_on == $past(spr_wdata[4]))
		else $error("data translation bit wrong");
	chk_resume_flag: assert property (
		st_wr |=> resumable_flag == $past(spr_wdata[1]))
		else $error("recoverable flag wrong");
	chk_byte_order: assert property (
		st_wr |=> byte_order_bit == $past(spr_wdata[0]))
		else $error("byte order bit wrong");
	chk_wide_mode: assert property (
		st_wr |=> wide_mode == $past(spr_wdata[63]))
		else $error("wide mode bit wrong");
	chk_fp_mode: assert property (
		st_wr |=> fp_trap_mode ==
		{$past(spr_wdata[11]), $past(spr_wdata[8])})
		else $error("float trap mode wrong");
	chk_vid_value: assert property (
		vid_rd ##0 !user_mode_bit |=> !spr_priv_fault &&
		spr_rdata == {32'h0, VERSION_CODE, REVISION_LEVEL})
		else $error("version value wrong");
	chk_vid_priv: assert property (
		vid_rd ##0 user_mode_bit |=>
		spr_priv_fault && spr_rdata == 64'h0)
		else $error("user version read not refused");
	chk_power_up: assert property (
		$rose(arst_n) |-> wide_mode && !user_mode_bit
		&& !insn_xlate_on && !data_xlate_on && !resumable_flag
		&& !byte_order_bit && fp_trap_mode == FP_TRAP_OFF)
		else $error("power-up state wrong");
endmodule

// Attach to every instance of the bank
bind cpu_state_regs cpu_state_regs_checker u_chk (.clk, .arst_n, .spr_sel,
	.spr_rd_en, .spr_wr_en, .spr_wdata, .spr_rdata, .spr_rd_valid,
	.spr_priv_fault, .wide_mode, .user_mode_bit, .insn_xlate_on,
	.data_xlate_on, .resumable_flag, .byte_order_bit, .fp_trap_mode);
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the processor state register bank
`default_nettype none
module tb_top import cpu_state_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;

	// Defined state bits; unspecified power-up bits are masked off
	localparam logic [63:0] DEF = 64'h8000_0000_0005_ff33;
	localparam logic [63:0] ONES = 64'hffff_ffff_ffff_ffff;
	localparam logic [63:0] VID = {32'h0, VERSION_CODE, REVISION_LEVEL};
	logic clk = 1'b0, arst_n = 1'b0, spr_rd_en = 1'b0, spr_wr_en = 1'b0;
	spr_sel_t spr_sel = SPR_STATE;
	logic [63:0] spr_wdata = 64'h0, spr_rdata, got, table_base_addr;
	logic spr_rd_valid, spr_priv_fault, wide_mode, nap_enable, trap_byte_order;
	logic ext_irq_on, user_mode_bit, float_unit_on, mcheck_on, branch_trace;
	logic single_step_trace, insn_xlate_on, data_xlate_on, perf_mark;
	logic resumable_flag, byte_order_bit, fp_exc_enabled, fp_precise;
	logic fp_recoverable, table_size_over_limit, table_size_over_va64;
	fp_trap_mode_t fp_trap_mode;
	logic [EXTRA_HASH_MAX-1:0] table_hash_mask;
	logic [5:0] table_index_bits;
	int n_fail = 0, total_checks = 0;
	int sizes [7] = '{0, 3, 11, 25, 26, 27, 28};
	logic [63:0] pat [4] = '{64'h37, 64'h8000_0000_0000_0000, 64'h12,
		64'h5_f600};
	logic [63:0] ctrl_seen;

	// Remaining control outputs placed back at their state word positions
	assign ctrl_seen = {45'h0, nap_enable, 1'b0, trap_byte_order, ext_irq_on,
		user_mode_bit, float_unit_on, mcheck_on, 1'b0, single_step_trace,
		branch_trace, 9'h0};

	cpu_state_regs dut (.clk, .arst_n, .spr_sel, .spr_rd_en, .spr_wr_en,
		.spr_wdata, .spr_rdata, .spr_rd_valid, .spr_priv_fault, .wide_mode,
		.nap_enable, .trap_byte_order, .ext_irq_on, .user_mode_bit,
		.float_unit_on, .mcheck_on, .single_step_trace, .branch_trace,
		.insn_xlate_on, .data_xlate_on, .perf_mark, .resumable_flag,
		.byte_order_bit, .fp_trap_mode, .fp_exc_enabled, .fp_precise,
		.fp_recoverable, .table_base_addr, .table_hash_mask,
		.table_index_bits, .table_size_over_limit, .table_size_over_va64);

	always #4 clk = ~clk;

	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One-cycle write strobe, launched just after an edge
	task automatic wr(input spr_sel_t s, input logic [63:0] d);
		@(posedge clk);
		#1;
		spr_sel = s;
		spr_wdata = d;
		spr_wr_en = 1'b1;
		@(posedge clk);
		#1;
		spr_wr_en = 1'b0;
	endtask

	// Read answer lands exactly one edge after the request
	task automatic rd(input spr_sel_t s);
		@(posedge clk);
		#1;
		spr_sel = s;
		spr_rd_en = 1'b1;
		@(posedge clk);
		#1;
		spr_rd_en = 1'b0;
		chk("rd_valid", 64'h1, 64'(spr_rd_valid));
		got = spr_rdata;
	endtask

	task automatic finish_test;
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Cut a hang short well past the expected run length
	initial
	begin
		#50000;
		n_fail++;
		finish_test();
	end

	initial
	begin
		int n;
		repeat (12) @(posedge clk);
		#1;
		arst_n = 1'b1;
		rd(SPR_STATE);
		chk("state_reset", 64'h8000_0000_0000_0000, got & DEF);
		// Set and clear the low and wide controls both ways; the ctrl_bits group is only set, by the last pattern
		foreach (pat[i])
		begin
			wr(SPR_STATE, pat[i]);
			chk("insn_xlate", 64'(pat[i][5]), 64'(insn_xlate_on));
			chk("data_xlate", 64'(pat[i][4]), 64'(data_xlate_on));
			chk("resumable", 64'(pat[i][1]), 64'(resumable_flag));
			chk("byte_order", 64'(pat[i][0]), 64'(byte_order_bit));
			chk("perf_mark", 64'(pat[i][2]), 64'(perf_mark));
			chk("wide_mode", 64'(pat[i][63]), 64'(wide_mode));
			chk("ctrl_bits", pat[i] & 64'h5_f600, ctrl_seen);
			rd(SPR_STATE);
			chk("state_rd", pat[i] & DEF, got & DEF);
		end
		// Every float trap mode encoding
		for (int m = 0; m < 4; m++)
		begin
			wr(SPR_STATE, {52'h0, m[1], 2'b0, m[0], 8'h0});
			chk("fp_mode", 64'(m), 64'(fp_trap_mode));
			chk("fp_exc_on", 64'(m != 0), 64'(fp_exc_enabled));
			chk("fp_precise", 64'(m == 3), 64'(fp_precise));
			chk("fp_recov", 64'(m >= 2), 64'(fp_recoverable));
		end
		rd(SPR_VERSION);
		chk("version", VID, got);
		chk("ver_fault", 64'h0, 64'(spr_priv_fault));
		wr(SPR_VERSION, ONES);
		rd(SPR_VERSION);
		chk("version_kept", VID, got);
		wr(SPR_SEGPTR, ONES);
		rd(SPR_SEGPTR);
		chk("segptr", 64'h0, got);
		// User mode: version read is refused
		wr(SPR_STATE, 64'h4000);
		rd(SPR_VERSION);
		chk("ver_user", 64'h0, got);
		chk("ver_fault", 64'h1, 64'(spr_priv_fault));
		// Largest legal table: size 28, low 28 base bits clear, reserved set
		wr(SPR_PTDESC, 64'hffff_c000_0003_fffc);
		rd(SPR_PTDESC);
		chk("ptdesc", 64'h3fff_c000_0000_001c, got);
		chk("table_base", 64'h3fff_c000_0000_0000, table_base_addr);
		// Size field boundaries up to the software limit
		foreach (sizes[i])
		begin
			n = sizes[i];
			wr(SPR_PTDESC, 64'(sizes[i]));
			chk("hash_mask", (64'h1 << n) - 64'h1, 64'(table_hash_mask));
			chk("index_bits", 64'(11 + n), 64'(table_index_bits));
			chk("over_28", 64'(sizes[i] > 28), 64'(table_size_over_limit));
			chk("over_25", 64'(sizes[i] > 25), 64'(table_size_over_va64));
		end
		// Second reset in mid-run
		arst_n = 1'b0;
		@(posedge clk);
		#1;
		arst_n = 1'b1;
		chk("user_reset", 64'h0, 64'(user_mode_bit));
		chk("wide_reset", 64'h1, 64'(wide_mode));
		chk("ctrl_reset", 64'h0, ctrl_seen);
		finish_test();
	end
endmodule
`default_nettype wire
